// >>> hw/vor_regs.sv
// Oscillator output configuration bank written indirectly through main register 05h
//
// Summary of operation
// - Priority code 01 power, 11 performance
// - Reset leaves power priority selected
// - Bit 2 enables positive output leg
// - Bit 3 enables negative output leg
// - Bit 4 enables internal bias termination
// - Bit 5 adds termination resistance per leg
// - Mute mode field bits 8:7, default 1
// - Indirect write: id, address, data fields
// - Divide ratio zero mutes the output
`timescale 1ns/1ns
module vor_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ind_wr_en,
  input wire logic [vor_pkg::IND_W-1:0] ind_wr_data,
  output vor_pkg::vor_ctrl_type ctrl,
  output vor_pkg::vor_cal_type cal
);

  logic [vor_pkg::REG_W-1:0] div_q;
  logic [vor_pkg::REG_W-1:0] div_d;
  logic [vor_pkg::REG_W-1:0] cfg_q;
  logic [vor_pkg::REG_W-1:0] cfg_d;
  logic [vor_pkg::REG_W-1:0] bias_q;
  logic [vor_pkg::REG_W-1:0] bias_d;
  logic [vor_pkg::REG_W-1:0] coarse_q;
  logic [vor_pkg::REG_W-1:0] coarse_d;
  logic [vor_pkg::REG_W-1:0] upper_q;
  logic [vor_pkg::REG_W-1:0] upper_d;
  vor_pkg::vor_ctrl_type ctrl_d;
  vor_pkg::vor_ctrl_type ctrl_q;
  logic hit;
  logic [vor_pkg::IND_ADDR_W-1:0] waddr;
  logic [vor_pkg::REG_W-1:0] wdata;

  assign hit = ind_wr_en &&
    (ind_wr_data[vor_pkg::IND_ID_LSB +: vor_pkg::IND_ID_W] == vor_pkg::SUBSYS_ID);
  assign waddr = ind_wr_data[vor_pkg::IND_ADDR_LSB +: vor_pkg::IND_ADDR_W];
  assign wdata = ind_wr_data[vor_pkg::IND_DATA_LSB +: vor_pkg::REG_W];

  // Shadow next values; nothing in the bank is readable
  always_comb
  begin
    div_d = div_q;
    cfg_d = cfg_q;
    bias_d = bias_q;
    coarse_d = coarse_q;
    upper_d = upper_q;
    if (hit)
    begin
      unique case (waddr)
        vor_pkg::ADDR_OUTPUT_DIVIDE: div_d = wdata;
        vor_pkg::ADDR_VCO_OUTPUT_CONFIG:
        begin
          cfg_d = wdata;
          cfg_d[vor_pkg::CFG_RSVD_BIT] = 1'b0;
        end
        vor_pkg::ADDR_VCO_CAL_BIAS_RESERVED: bias_d = wdata;
        vor_pkg::ADDR_VCO_COARSE_CAL_RESERVED: coarse_d = wdata;
        vor_pkg::ADDR_VCO_UPPER_CAL_RESERVED: upper_d = wdata;
        default:
        begin
          // Other addresses belong to registers outside this bank
        end
      endcase
    end
  end

  // Decode of the configuration shadow into output stage controls
  always_comb
  begin
    ctrl_d = '0;
    if (cfg_d[vor_pkg::CFG_PRIO_LSB +: 2] == vor_pkg::PRIO_PERFORMANCE)
    begin
      ctrl_d.priority_mode = vor_pkg::VOR_PERFORMANCE_PRIORITY;
    end
    else
    begin
      // Code 01 and the unsupported codes fall back to low current
      ctrl_d.priority_mode = vor_pkg::VOR_POWER_PRIORITY;
    end
    ctrl_d.positive_output_leg_en = cfg_d[vor_pkg::CFG_POS_LEG_BIT];
    ctrl_d.negative_output_leg_en = cfg_d[vor_pkg::CFG_NEG_LEG_BIT];
    ctrl_d.internal_term_en = cfg_d[vor_pkg::CFG_INT_TERM_BIT];
    ctrl_d.extra_resistance_en = cfg_d[vor_pkg::CFG_EXTRA_RES_BIT];
    ctrl_d.mute_mode = cfg_d[vor_pkg::CFG_MUTE_LSB +: 2];
    ctrl_d.divide_ratio = div_d[vor_pkg::DIV_W-1:0];
    // A zero divide ratio mutes in every mute mode
    ctrl_d.output_muted = (div_d[vor_pkg::DIV_W-1:0] == vor_pkg::DIV_MUTE);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= vor_pkg::RST_OUTPUT_DIVIDE;
      cfg_q <= vor_pkg::RST_VCO_OUTPUT_CONFIG;
      bias_q <= vor_pkg::RST_VCO_CAL_BIAS_RESERVED;
      coarse_q <= vor_pkg::RST_VCO_COARSE_CAL_RESERVED;
      upper_q <= vor_pkg::RST_VCO_UPPER_CAL_RESERVED;
      ctrl_q <= '0;
    end
    else
    begin
      div_q <= div_d;
      cfg_q <= cfg_d;
      bias_q <= bias_d;
      coarse_q <= coarse_d;
      upper_q <= upper_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;
  assign cal.cal_bias = bias_q;
  assign cal.coarse_calibration = coarse_q;
  assign cal.upper_cal = upper_q;

endmodule : vor_regs

// >>> hw/vor_pkg.sv
// Package with constants and types of the oscillator output configuration bank
package vor_pkg;
  // Indirect write word carried by main-bank register 05h
  localparam int unsigned IND_ID_LSB = 0;
  localparam int unsigned IND_ID_W = 3;
  localparam int unsigned IND_ADDR_LSB = 3;
  localparam int unsigned IND_ADDR_W = 4;
  localparam int unsigned IND_DATA_LSB = 7;
  localparam int unsigned REG_W = 9;
  localparam int unsigned IND_W = IND_DATA_LSB + REG_W;
  localparam logic [IND_ID_W-1:0] SUBSYS_ID = 3'h0;

  // Register addresses inside the oscillator subsystem
  localparam logic [IND_ADDR_W-1:0] ADDR_OUTPUT_DIVIDE = 4'h2;
  localparam logic [IND_ADDR_W-1:0] ADDR_VCO_OUTPUT_CONFIG = 4'h3;
  localparam logic [IND_ADDR_W-1:0] ADDR_VCO_CAL_BIAS_RESERVED = 4'h4;
  localparam logic [IND_ADDR_W-1:0] ADDR_VCO_COARSE_CAL_RESERVED = 4'h5;
  localparam logic [IND_ADDR_W-1:0] ADDR_VCO_UPPER_CAL_RESERVED = 4'h6;

  // Field positions of vco_output_config
  localparam int unsigned CFG_PRIO_LSB = 0;
  localparam int unsigned CFG_POS_LEG_BIT = 2;
  localparam int unsigned CFG_NEG_LEG_BIT = 3;
  localparam int unsigned CFG_INT_TERM_BIT = 4;
  localparam int unsigned CFG_EXTRA_RES_BIT = 5;
  localparam int unsigned CFG_RSVD_BIT = 6;
  localparam int unsigned CFG_MUTE_LSB = 7;
  localparam int unsigned DIV_W = 6;

  // Priority and mute codes
  localparam logic [1:0] PRIO_POWER = 2'h1;
  localparam logic [1:0] PRIO_PERFORMANCE = 2'h3;
  localparam logic [1:0] MUTE_BY_DIVIDE = 2'h0;
  localparam logic [DIV_W-1:0] DIV_MUTE = 6'h00;

  // Reset values
  localparam logic [REG_W-1:0] RST_OUTPUT_DIVIDE = 9'h001;
  localparam logic [REG_W-1:0] RST_VCO_OUTPUT_CONFIG = 9'h091;
  localparam logic [REG_W-1:0] RST_VCO_CAL_BIAS_RESERVED = 9'h0c9;
  localparam logic [REG_W-1:0] RST_VCO_COARSE_CAL_RESERVED = 9'h0aa;
  localparam logic [REG_W-1:0] RST_VCO_UPPER_CAL_RESERVED = 9'h0ff;

  typedef enum logic {VOR_POWER_PRIORITY, VOR_PERFORMANCE_PRIORITY} vor_prio_type;

  // Decoded controls handed to the analog output stage
  typedef struct packed {
    vor_prio_type priority_mode;
    logic positive_output_leg_en;
    logic negative_output_leg_en;
    logic internal_term_en;
    logic extra_resistance_en;
    logic [1:0] mute_mode;
    logic output_muted;
    logic [DIV_W-1:0] divide_ratio;
  } vor_ctrl_type;

  // Reserved calibration and bias shadows
  typedef struct packed {
    logic [REG_W-1:0] cal_bias;
    logic [REG_W-1:0] coarse_calibration;
    logic [REG_W-1:0] upper_cal;
  } vor_cal_type;
endpackage : vor_pkg

// >>> dv/vor_regs_chk.sv
// Port assertions for the oscillator output bank
`timescale 1ns/1ns
module vor_regs_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ind_wr_en,
  input wire logic [vor_pkg::IND_W-1:0] ind_wr_data,
  input wire vor_pkg::vor_ctrl_type ctrl,
  input wire vor_pkg::vor_cal_type cal
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [8:0] d_q;
  logic tk;
  assign tk = ind_wr_en && ind_wr_data[2:0] == 3'h0;
  always_ff @(posedge core_clk) d_q <= ind_wr_data[15:7];
  a_prio_code: assert property (tk && ind_wr_data[6:3] == 4'h3 |=>
    ctrl.priority_mode == (d_q[1:0] == 2'h3)) else $error("prio");
  a_leg_enables: assert property (tk && ind_wr_data[6:3] == 4'h3 |=>
    ctrl.positive_output_leg_en == d_q[2] &&
    ctrl.negative_output_leg_en == d_q[3]) else $error("leg");
  a_term_bit: assert property (tk && ind_wr_data[6:3] == 4'h3 |=>
    ctrl.internal_term_en == d_q[4]) else $error("term");
  a_extra_res: assert property (tk && ind_wr_data[6:3] == 4'h3 |=>
    ctrl.extra_resistance_en == d_q[5]) else $error("res");
  a_mute_field: assert property (tk && ind_wr_data[6:3] == 4'h3 |=>
    ctrl.mute_mode == d_q[8:7]) else $error("mute");
  a_div_mute: assert property (tk && ind_wr_data[6:3] == 4'h2 |=>
    ctrl.output_muted == (d_q[5:0] == 6'h00) && ctrl.divide_ratio == d_q[5:0]) else $error("div");
  a_cal_shadow: assert property (tk && ind_wr_data[6:3] == 4'h4 |=>
    cal.cal_bias == d_q) else $error("cal");
  a_coarse_shadow: assert property (tk && ind_wr_data[6:3] == 4'h5 |=>
    cal.coarse_calibration == d_q) else $error("coarse");
  a_upper_shadow: assert property (tk && ind_wr_data[6:3] == 4'h6 |=>
    cal.upper_cal == d_q) else $error("upper");
  a_foreign_id: assert property (ind_wr_en && ind_wr_data[2:0] != 3'h0 |=>
    $stable(ctrl) && $stable(cal)) else $error("foreign id");
  a_unmapped_addr: assert property (tk &&
    (ind_wr_data[6:3] < 4'h2 || ind_wr_data[6:3] > 4'h6) |=>
    $stable(ctrl) && $stable(cal)) else $error("unmapped");
  a_reset_state: assert property ($rose(arst_n) |=> ctrl.internal_term_en &&
    ctrl.mute_mode == 2'h1 && !ctrl.priority_mode) else $error("reset");
endmodule : vor_regs_chk
bind vor_regs vor_regs_chk chk (.core_clk(core_clk), .arst_n(arst_n), .ind_wr_en(ind_wr_en),
  .ind_wr_data(ind_wr_data), .ctrl(ctrl), .cal(cal));

// >>> dv/vor_host.sv
// Host model issuing indirect writes through main register 05h
`timescale 1ns/1ns
module vor_host (
  input wire logic core_clk,
  output logic ind_wr_en,
  output logic [vor_pkg::IND_W-1:0] ind_wr_data
);
  initial ind_wr_en = 1'b0;
  initial ind_wr_data = '0;
  // Callers keep priority codes supported and reserved registers at defaults, but some config writes set reserved bit 6
  task automatic wr(input logic [2:0] id, input logic [3:0] a, input logic [8:0] d);
    @(posedge core_clk) #1;
    ind_wr_en = 1'b1;
    ind_wr_data = {d, a, id};
    @(posedge core_clk) #1;
    ind_wr_en = 1'b0;
    ind_wr_data = ~ind_wr_data;
  endtask : wr
endmodule : vor_host

// >>> dv/vor_regs_tb_top.sv
// Testbench for the oscillator output bank
`timescale 1ns/1ns
module vor_regs_tb_top;
  logic core_clk;
  logic arst_n;
  logic ind_wr_en;
  logic [vor_pkg::IND_W-1:0] ind_wr_data;
  vor_pkg::vor_ctrl_type ctrl;
  vor_pkg::vor_cal_type cal;
  logic [13:0] exp_ctrl;
  logic [8:0] cfgs [4] = '{9'h1ef, 9'h02d, 9'h153, 9'h091};
  int bad_count = 0;
  int n_tests = 0;
  vor_regs dut (.core_clk(core_clk), .arst_n(arst_n), .ind_wr_en(ind_wr_en),
    .ind_wr_data(ind_wr_data), .ctrl(ctrl), .cal(cal));
  vor_host host (.core_clk(core_clk), .ind_wr_en(ind_wr_en), .ind_wr_data(ind_wr_data));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // Write, track expected decode, compare after the update edge
  task automatic put(input logic [2:0] id, input logic [3:0] a, input logic [8:0] d);
    host.wr(id, a, d);
    if (id == 3'h0 && a == 4'h3)
      exp_ctrl[13:7] = {d[1:0] == 2'h3, d[2], d[3], d[4], d[5], d[8:7]};
    if (id == 3'h0 && a == 4'h2)
      exp_ctrl[6:0] = {d[5:0] == 6'h00, d[5:0]};
    chk(ctrl, exp_ctrl);
  endtask : put
  initial
  begin
    #20000;
    bad_count++;
    final_report();
  end
  initial
  begin
    arst_n = 1'b0;
    exp_ctrl = 14'h0481;
    repeat (12) @(posedge core_clk);
    #1 arst_n = 1'b1;
    @(posedge core_clk) #1;
    chk(ctrl, exp_ctrl);
    foreach (cfgs[i]) put(3'h0, 4'h3, cfgs[i]);
    put(3'h0, 4'h2, 9'h000);
    put(3'h0, 4'h2, 9'h03e);
    put(3'h1, 4'h3, 9'h000);
    put(3'h0, 4'h7, 9'h000);
    put(3'h0, 4'h4, 9'h0c9);
    put(3'h0, 4'h5, 9'h0aa);
    put(3'h0, 4'h6, 9'h0ff);
    chk(cal, {9'h0c9, 9'h0aa, 9'h0ff});
    // Mid-run reset from a non-default state
    put(3'h0, 4'h3, 9'h1ef);
    arst_n = 1'b0;
    exp_ctrl = 14'h0481;
    repeat (2) @(posedge core_clk);
    #1;
    chk(cal, {9'h0c9, 9'h0aa, 9'h0ff});
    arst_n = 1'b1;
    @(posedge core_clk) #1;
    chk(ctrl, exp_ctrl);
    put(3'h0, 4'h2, 9'h000);
    final_report();
  end
endmodule : vor_regs_tb_top
